// ---- pkg/core_ctrl_pkg.sv ----
package core_ctrl_pkg;
  // ----------------------------------------
  // special function register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STACK_POINTER_LOW = 8'h81;
  localparam logic [7:0] OFS_FLASH_WAIT_CYCLES = 8'h92;
  localparam logic [7:0] OFS_STACK_TOP_BYTE = 8'h9B;
  localparam logic [7:0] OFS_ADDRESS_MODE_CONTROL = 8'h9D;
  localparam logic [7:0] OFS_STATUS_FLAGS_WORD = 8'hD0;
  localparam logic [7:0] OFS_RI_PAGE_REGISTER = 8'hDA;
  localparam logic [7:0] OFS_WORK_REGISTER_A = 8'hE0;
  localparam logic [7:0] OFS_AUX_OPERAND_REGISTER = 8'hF0;
  localparam logic [7:0] OFS_SUPPLY_DETECT_CTRL = 8'hDF;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE_ZERO = 8'h00;
  localparam logic [7:0] RST_FLASH_WAIT_CYCLES = 8'h07;
  localparam logic [19:0] RST_PROGRAM_COUNTER = 20'h0F000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int AMC_SELECT_LSB = 0;
  localparam int AMC_SELECT_MSB = 1;
  localparam int AMC_STACK_EXT_BIT = 2;
  localparam int AMC_RI_SOURCE_BIT = 3;
  localparam int SDC_ENABLE_BIT = 7;
  localparam int SDC_THRESH_LSB = 0;
  localparam int SDC_THRESH_MSB = 3;
  localparam int WAIT_FIELD_MSB = 3;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PIN_FILTER_NS = 5000;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_SYNC_STAGES = 2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_WAIT,
    FETCH_DONE
  } fetch_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

  typedef struct packed {
    logic push;
    logic pop;
    logic [7:0] push_data;
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } core_op_s;
endpackage : core_ctrl_pkg

// ---- rtl/core_ctrl.sv ----
// Overview of operation
// - every reset source returns all registers to their defaults
// - supply reset held while core supply is below ninety percent
// - supply reset asserted when interference drops core supply below seventy percent
// - low-supply reset off after reset; software enables it; threshold adjustable
// - low-supply reset drives the external reset pin low
// - external reset pin lows under five microseconds are filtered out
// - every reset enables watchdog reset with maximum timeout
// - program counter starts at 0x0F000 after reset
// - internal oscillator selected as system clock after reset
// - internal oscillator runs except in stop mode
// - push writes at stack pointer plus one; pop reads at stack pointer
// - twenty-bit mode stack address is top byte with stack pointer
// - select 00 gives sixteen-bit program, 1x twenty-bit; data stays sixteen-bit
// - stack indicator reads 0 for internal stack, 1 for extended stack
// - register-indirect page from port 2 or page register by source bit
// - wait field n inserts n plus one cycles on program fetches only
// - wait register resets to 0x07 and changes only on software write
// - work register and auxiliary register are bit addressable
// - status word: carry, half carry, general, bank bits, overflow, user, parity
`timescale 1ns/1ps
`default_nettype none
module core_ctrl
  import core_ctrl_pkg::*;
#(
  parameter int FILTER_CYCLES = PIN_FILTER_CYCLES
) (
  input wire logic ref_clk,
  input wire logic external_reset_pin_n,
  input wire logic core_supply_ok_90,
  input wire logic core_supply_ok_70,
  input wire logic supply_below_threshold,
  input wire logic external_reset_pin_n_in,
  input wire logic watchdog_timeout,
  input wire logic low_power_stop,
  input wire sfr_req_s sfr_req,
  input wire core_op_s core_op,
  input wire logic [7:0] port2_value,
  input wire logic fetch_req,
  output logic external_reset_pin_n_out,
  output logic external_reset_pin_n_oe,
  output logic core_rst_n,
  output logic [7:0] sfr_rdata,
  output logic [19:0] program_counter,
  output logic internal_oscillator_sel,
  output logic internal_oscillator_en,
  output logic watchdog_reset_en,
  output logic watchdog_timeout_max,
  output logic [15:0] stack_addr,
  output logic stack_wr,
  output logic [7:0] stack_wdata,
  output logic stack_rd,
  output logic [7:0] ri_high_byte,
  output logic twenty_bit_program_mode,
  output logic [3:0] supply_level_threshold,
  output logic fetch_done
);
  // ----------------------------------------
  // reset collection
  // ----------------------------------------
  logic [RESET_SYNC_STAGES-1:0] rst_sync_ff;
  logic pin_low_filtered;
  logic low_supply_reset;
  logic raw_rst_n;
  logic [31:0] pin_cnt_ff;
  logic pin_rst_ff;

  always_ff @(posedge ref_clk or negedge external_reset_pin_n) begin
    if (!external_reset_pin_n) begin
      pin_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end else if (external_reset_pin_n_in) begin
      pin_cnt_ff <= '0;
      pin_rst_ff <= 1'b0;
    end else if (pin_cnt_ff >= 32'(FILTER_CYCLES - 1)) begin
      pin_rst_ff <= 1'b1;
    end else begin
      pin_cnt_ff <= pin_cnt_ff + 32'd1;
    end
  end
  assign pin_low_filtered = pin_rst_ff;

  typedef struct packed {
    logic [7:0] sp;
    logic [7:0] wait_cfg;
    logic [7:0] top;
    logic [7:0] amc;
    logic [7:0] status_flags_word;
    logic [7:0] page;
    logic [7:0] acc;
    logic [7:0] aux;
    logic [7:0] sdc;
    logic [7:0] rdata;
    logic [15:0] saddr;
    logic swr;
    logic [7:0] swdata;
    logic srd;
    logic [7:0] rihb;
    logic [3:0] wcnt;
    fetch_state_e fst;
    logic fdone;
    logic pin_drive;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  // held while the supply stays low, since the reset it causes clears the enable
  logic lsr_hold_ff;
  always_ff @(posedge ref_clk or negedge external_reset_pin_n) begin
    if (!external_reset_pin_n) begin
      lsr_hold_ff <= 1'b0;
    end else begin
      lsr_hold_ff <= supply_below_threshold & (cur_ff.sdc[SDC_ENABLE_BIT] | lsr_hold_ff);
    end
  end
  assign low_supply_reset = lsr_hold_ff;
  assign raw_rst_n = external_reset_pin_n & core_supply_ok_90 & core_supply_ok_70 & ~pin_low_filtered &
                     ~watchdog_timeout & ~low_supply_reset;

  always_ff @(posedge ref_clk or negedge raw_rst_n) begin
    if (!raw_rst_n) begin
      rst_sync_ff <= '0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[RESET_SYNC_STAGES-2:0], 1'b1};
    end
  end

  logic srst_n;
  assign srst_n = rst_sync_ff[RESET_SYNC_STAGES-1];

  // ----------------------------------------
  // register file and core state
  // ----------------------------------------
  logic [7:0] bit_base;
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.swr = 1'b0;
    nxt_cur.srd = 1'b0;
    nxt_cur.fdone = 1'b0;
    nxt_cur.pin_drive = low_supply_reset;
    bit_base = {core_op.bit_addr[7:3], 3'b000};
    if (sfr_req.wr) begin
      unique case (sfr_req.addr)
        OFS_STACK_POINTER_LOW: nxt_cur.sp = sfr_req.wdata;
        OFS_FLASH_WAIT_CYCLES: nxt_cur.wait_cfg = {4'h0, sfr_req.wdata[WAIT_FIELD_MSB:0]};
        OFS_STACK_TOP_BYTE: nxt_cur.top = sfr_req.wdata;
        OFS_ADDRESS_MODE_CONTROL: begin
          nxt_cur.amc[AMC_SELECT_MSB:AMC_SELECT_LSB] = sfr_req.wdata[AMC_SELECT_MSB:AMC_SELECT_LSB];
          nxt_cur.amc[AMC_RI_SOURCE_BIT] = sfr_req.wdata[AMC_RI_SOURCE_BIT];
        end
        OFS_STATUS_FLAGS_WORD: nxt_cur.status_flags_word = sfr_req.wdata;
        OFS_RI_PAGE_REGISTER: nxt_cur.page = sfr_req.wdata;
        OFS_WORK_REGISTER_A: nxt_cur.acc = sfr_req.wdata;
        OFS_AUX_OPERAND_REGISTER: nxt_cur.aux = sfr_req.wdata;
        OFS_SUPPLY_DETECT_CTRL: nxt_cur.sdc = {sfr_req.wdata[SDC_ENABLE_BIT], 3'b000,
                                               sfr_req.wdata[SDC_THRESH_MSB:SDC_THRESH_LSB]};
        default: ;
      endcase
    end
    if (core_op.bit_wr) begin
      if (bit_base == OFS_WORK_REGISTER_A) begin
        nxt_cur.acc[core_op.bit_addr[2:0]] = core_op.bit_val;
      end else if (bit_base == OFS_AUX_OPERAND_REGISTER) begin
        nxt_cur.aux[core_op.bit_addr[2:0]] = core_op.bit_val;
      end else if (bit_base == OFS_STATUS_FLAGS_WORD) begin
        nxt_cur.status_flags_word[core_op.bit_addr[2:0]] = core_op.bit_val;
      end
    end
    // stack mode indicator follows the program mode
    nxt_cur.amc[AMC_STACK_EXT_BIT] = nxt_cur.amc[AMC_SELECT_MSB];
    if (core_op.push) begin
      nxt_cur.sp = cur_ff.sp + 8'h01;
      nxt_cur.saddr = cur_ff.amc[AMC_SELECT_MSB] ? {cur_ff.top, cur_ff.sp + 8'h01} :
                      {8'h00, cur_ff.sp + 8'h01};
      nxt_cur.swr = 1'b1;
      nxt_cur.swdata = core_op.push_data;
    end else if (core_op.pop) begin
      nxt_cur.sp = cur_ff.sp - 8'h01;
      nxt_cur.saddr = cur_ff.amc[AMC_SELECT_MSB] ? {cur_ff.top, cur_ff.sp} : {8'h00, cur_ff.sp};
      nxt_cur.srd = 1'b1;
    end
    nxt_cur.rihb = cur_ff.amc[AMC_RI_SOURCE_BIT] ? cur_ff.page : port2_value;
    unique case (sfr_req.addr)
      OFS_STACK_POINTER_LOW: nxt_cur.rdata = cur_ff.sp;
      OFS_FLASH_WAIT_CYCLES: nxt_cur.rdata = cur_ff.wait_cfg;
      OFS_STACK_TOP_BYTE: nxt_cur.rdata = cur_ff.top;
      OFS_ADDRESS_MODE_CONTROL: nxt_cur.rdata = cur_ff.amc;
      OFS_STATUS_FLAGS_WORD: nxt_cur.rdata = cur_ff.status_flags_word;
      OFS_RI_PAGE_REGISTER: nxt_cur.rdata = cur_ff.page;
      OFS_WORK_REGISTER_A: nxt_cur.rdata = cur_ff.acc;
      OFS_AUX_OPERAND_REGISTER: nxt_cur.rdata = cur_ff.aux;
      OFS_SUPPLY_DETECT_CTRL: nxt_cur.rdata = cur_ff.sdc;
      default: nxt_cur.rdata = 8'h00;
    endcase
    // program fetch wait states
    unique case (cur_ff.fst)
      FETCH_IDLE: begin
        if (fetch_req) begin
          nxt_cur.wcnt = cur_ff.wait_cfg[WAIT_FIELD_MSB:0];
          nxt_cur.fst = (cur_ff.wait_cfg[WAIT_FIELD_MSB:0] == 4'h0) ? FETCH_DONE : FETCH_WAIT;
        end
      end
      FETCH_WAIT: begin
        nxt_cur.wcnt = cur_ff.wcnt - 4'h1;
        if (cur_ff.wcnt == 4'h1) begin
          nxt_cur.fst = FETCH_DONE;
        end
      end
      FETCH_DONE: begin
        nxt_cur.fdone = 1'b1;
        nxt_cur.fst = FETCH_IDLE;
      end
      default: nxt_cur.fst = FETCH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      cur_ff <= '{sp: RST_BYTE_ZERO, wait_cfg: RST_FLASH_WAIT_CYCLES, top: RST_BYTE_ZERO,
                  amc: RST_BYTE_ZERO, status_flags_word: RST_BYTE_ZERO, page: RST_BYTE_ZERO, acc: RST_BYTE_ZERO,
                  aux: RST_BYTE_ZERO, sdc: RST_BYTE_ZERO, rdata: RST_BYTE_ZERO, saddr: 16'h0000,
                  swr: 1'b0, swdata: RST_BYTE_ZERO, srd: 1'b0, rihb: RST_BYTE_ZERO, wcnt: 4'h0,
                  fst: FETCH_IDLE, fdone: 1'b0, pin_drive: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // reset-time outputs
  // ----------------------------------------
  logic [19:0] pc_ff;
  logic osc_sel_ff;
  logic osc_en_ff;
  logic wd_en_ff;
  logic wd_max_ff;
  always_ff @(posedge ref_clk or negedge srst_n) begin
    if (!srst_n) begin
      pc_ff <= RST_PROGRAM_COUNTER;
      osc_sel_ff <= 1'b1;
      osc_en_ff <= 1'b1;
      wd_en_ff <= 1'b1;
      wd_max_ff <= 1'b1;
    end else begin
      pc_ff <= pc_ff;
      osc_sel_ff <= osc_sel_ff;
      osc_en_ff <= ~low_power_stop;
      wd_en_ff <= wd_en_ff;
      wd_max_ff <= wd_max_ff;
    end
  end

  // pin driver and reset status are reset only by the external reset pin so they act during reset
  logic pin_oe_ff;
  logic core_rst_ff;
  always_ff @(posedge ref_clk or negedge external_reset_pin_n) begin
    if (!external_reset_pin_n) begin
      pin_oe_ff <= 1'b0;
      core_rst_ff <= 1'b0;
    end else begin
      pin_oe_ff <= low_supply_reset;
      core_rst_ff <= srst_n;
    end
  end

  assign external_reset_pin_n_out = 1'b0;
  assign external_reset_pin_n_oe = pin_oe_ff;
  assign core_rst_n = core_rst_ff;
  assign sfr_rdata = cur_ff.rdata;
  assign program_counter = pc_ff;
  assign internal_oscillator_sel = osc_sel_ff;
  assign internal_oscillator_en = osc_en_ff;
  assign watchdog_reset_en = wd_en_ff;
  assign watchdog_timeout_max = wd_max_ff;
  assign stack_addr = cur_ff.saddr;
  assign stack_wr = cur_ff.swr;
  assign stack_wdata = cur_ff.swdata;
  assign stack_rd = cur_ff.srd;
  assign ri_high_byte = cur_ff.rihb;
  assign twenty_bit_program_mode = cur_ff.amc[AMC_SELECT_MSB];
  assign supply_level_threshold = cur_ff.sdc[SDC_THRESH_MSB:SDC_THRESH_LSB];
  assign fetch_done = cur_ff.fdone;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_wait_reset_val: assert property (@(posedge ref_clk)
    $rose(srst_n) |-> cur_ff.wait_cfg == RST_FLASH_WAIT_CYCLES)
    else $error("wait register not 0x07 after reset");
  chk_wait_hold: assert property (@(posedge ref_clk) disable iff (!srst_n)
    !(sfr_req.wr && sfr_req.addr == OFS_FLASH_WAIT_CYCLES) |=> $stable(cur_ff.wait_cfg))
    else $error("wait register changed without write");
  chk_wait_write: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (sfr_req.wr && sfr_req.addr == OFS_FLASH_WAIT_CYCLES) |=>
      cur_ff.wait_cfg == {4'h0, $past(sfr_req.wdata[3:0])})
    else $error("wait register write not applied");
  chk_fetch_zero: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (cur_ff.fst == FETCH_IDLE && fetch_req && cur_ff.wait_cfg[3:0] == 4'h0) |-> ##2 fetch_done)
    else $error("fetch with zero field not done in two cycles");
  chk_fetch_seven: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (cur_ff.fst == FETCH_IDLE && fetch_req && cur_ff.wait_cfg[3:0] == 4'h7) |->
      ##1 !fetch_done [*8] ##1 fetch_done)
    else $error("fetch with field seven wrong length");
  chk_push_addr: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (core_op.push && !cur_ff.amc[1]) |=> stack_wr && stack_addr == {8'h00, $past(cur_ff.sp) + 8'h01})
    else $error("push address not pointer plus one");
  chk_push_ext: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (core_op.push && cur_ff.amc[1]) |=> stack_wr && stack_addr == {$past(cur_ff.top), $past(cur_ff.sp) + 8'h01})
    else $error("extended push address wrong");
  chk_pop_addr: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (core_op.pop && !core_op.push && cur_ff.amc[1]) |=>
      stack_rd && stack_addr == {$past(cur_ff.top), $past(cur_ff.sp)})
    else $error("extended pop address wrong");
  chk_pop_low: assert property (@(posedge ref_clk) disable iff (!srst_n)
    (core_op.pop && !core_op.push && !cur_ff.amc[1]) |=> stack_rd && stack_addr == {8'h00, $past(cur_ff.sp)})
    else $error("pop address not pointer");
  chk_page_src: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cur_ff.amc[3] |=> ri_high_byte == $past(cur_ff.page))
    else $error("page byte not from page register");
  chk_port2_src: assert property (@(posedge ref_clk) disable iff (!srst_n)
    !cur_ff.amc[3] |=> ri_high_byte == $past(port2_value))
    else $error("page byte not from port 2");
  chk_stack_flag: assert property (@(posedge ref_clk) disable iff (!srst_n)
    cur_ff.amc[2] == cur_ff.amc[1])
    else $error("stack indicator mismatches mode");
  chk_pc_start: assert property (@(posedge ref_clk)
    $rose(srst_n) |-> program_counter == RST_PROGRAM_COUNTER)
    else $error("start address wrong");
  chk_reset_defaults: assert property (@(posedge ref_clk)
    $rose(srst_n) |-> watchdog_reset_en && watchdog_timeout_max && internal_oscillator_sel)
    else $error("watchdog or clock choice wrong after reset");
  chk_osc_stop: assert property (@(posedge ref_clk) disable iff (!srst_n)
    low_power_stop |=> !internal_oscillator_en)
    else $error("oscillator still enabled in stop");
  chk_pin_drive: assert property (@(posedge ref_clk) disable iff (!external_reset_pin_n)
    low_supply_reset |=> external_reset_pin_n_oe)
    else $error("reset pin not driven on low supply");
  chk_pin_filter: assert property (@(posedge ref_clk) disable iff (!external_reset_pin_n)
    $rose(pin_rst_ff) |-> pin_cnt_ff == 32'(FILTER_CYCLES - 1))
    else $error("pin reset taken before filter time");
  chk_core_reset: assert property (@(posedge ref_clk) disable iff (!external_reset_pin_n)
    !srst_n |=> !core_rst_n)
    else $error("core reset status not following internal reset");
endmodule : core_ctrl
`default_nettype wire

// ---- tb/reset_circuit.sv ----
`timescale 1ns/1ps
`default_nettype none
module reset_circuit (
  input wire logic ref_clk,
  input wire logic pin_oe,
  input wire logic pin_out,
  output logic pin_level
);
  logic pulled = 1'b0;
  // pull-up wins unless the button or the device drives low
  assign pin_level = ~(pulled | (pin_oe & ~pin_out));
  // ----------------------------------------
  // button press for n cycles
  // ----------------------------------------
  task automatic press(input int n);
    pulled = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1 pulled = 1'b0;
  endtask : press
endmodule : reset_circuit
`default_nettype wire

// ---- tb/core_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_ctrl_tb;
  import core_ctrl_pkg::*;
  localparam int FC = 4;
  logic ref_clk = 1'b0, external_reset_pin_n = 1'b0, ok90 = 1'b1, ok70 = 1'b1, below = 1'b0;
  logic wdt = 1'b0, stop = 1'b0, freq = 1'b0, oe_seen = 1'b0, bad;
  logic [7:0] p2 = 8'h00, d, s, t, x;
  sfr_req_s req = '0;
  core_op_s op = '0;
  logic pin_out, pin_oe, pin_lvl, crst, osel, oen, wden, wdmax, swr, srd, tbm, fdone;
  logic [7:0] rdata, swd, rih;
  logic [19:0] pc;
  logic [15:0] saddr;
  logic [3:0] thr;
  int failures = 0, n_tests = 0, seed = 75, k;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pin_oe === 1'b1) oe_seen <= 1'b1;
  core_ctrl #(.FILTER_CYCLES(FC)) DUT (.ref_clk(ref_clk), .external_reset_pin_n(external_reset_pin_n), .core_supply_ok_90(ok90),
    .core_supply_ok_70(ok70), .supply_below_threshold(below), .external_reset_pin_n_in(pin_lvl),
    .watchdog_timeout(wdt), .low_power_stop(stop), .sfr_req(req), .core_op(op), .port2_value(p2),
    .fetch_req(freq), .external_reset_pin_n_out(pin_out), .external_reset_pin_n_oe(pin_oe),
    .core_rst_n(crst), .sfr_rdata(rdata), .program_counter(pc), .internal_oscillator_sel(osel),
    .internal_oscillator_en(oen), .watchdog_reset_en(wden), .watchdog_timeout_max(wdmax),
    .stack_addr(saddr), .stack_wr(swr), .stack_wdata(swd), .stack_rd(srd), .ri_high_byte(rih),
    .twenty_bit_program_mode(tbm), .supply_level_threshold(thr), .fetch_done(fdone));
  reset_circuit pin (.ref_clk(ref_clk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin_lvl));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  function automatic logic sig(input int w);
    case (w)
      0: return swr;
      1: return srd;
      2: return fdone;
      default: return crst;
    endcase
  endfunction : sig
  task automatic waitsig(input int w, input logic v);
    k = 0;
    while (sig(w) !== v) begin
      if (k == 80) begin
        failures++;
        end_of_test;
      end
      cyc(1);
      k++;
    end
  endtask : waitsig
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    cyc(1);
    req.rd = 1'b0;
    chk(rdata, exp);
    cyc(1);
  endtask : rd
  task automatic quiet;
    bad = 1'b0;
    repeat (12) begin
      cyc(1);
      if (crst !== 1'b1) bad = 1'b1;
    end
  endtask : quiet
  task automatic src(input int w);
    wr(OFS_WORK_REGISTER_A, 8'h5A);
    oe_seen = 1'b0;
    case (w)
      0: ok90 = 1'b0;
      1: ok70 = 1'b0;
      2: wdt = 1'b1;
      3: fork pin.press(3 * FC); join_none
      4: begin
        wr(OFS_SUPPLY_DETECT_CTRL, 8'h80);
        below = 1'b1;
      end
      default: external_reset_pin_n = 1'b0;
    endcase
    waitsig(3, 1'b0);
    cyc(2);
    {external_reset_pin_n, ok90, ok70, wdt, below} = 5'b11100;
    waitsig(3, 1'b1);
    cyc(3);
    chk(oe_seen, w == 4);
    rd(OFS_WORK_REGISTER_A, 8'h00);
    rd(OFS_FLASH_WAIT_CYCLES, RST_FLASH_WAIT_CYCLES);
    rd(OFS_SUPPLY_DETECT_CTRL, 8'h00);
    chk(pc, RST_PROGRAM_COUNTER);
    chk({osel, oen}, 2'b11);
    chk({wden, wdmax}, 2'b11);
  endtask : src
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(2);
    external_reset_pin_n = 1'b1;
    waitsig(3, 1'b1);
    cyc(3);
    src(5);
    foreach (d[i]) begin
      x = $random(seed);
      wr(OFS_STACK_POINTER_LOW + 8'(i), x);
    end
    wr(8'hC1, 8'hFF);
    rd(8'hC1, 8'h00);
    for (int i = 0; i < 7; i++) begin
      t = 8'({OFS_STACK_POINTER_LOW, OFS_FLASH_WAIT_CYCLES, OFS_STACK_TOP_BYTE, OFS_STATUS_FLAGS_WORD,
        OFS_RI_PAGE_REGISTER, OFS_WORK_REGISTER_A, OFS_AUX_OPERAND_REGISTER} >> (8 * (6 - i)));
      x = $random(seed);
      wr(t, x);
      rd(t, (t == OFS_FLASH_WAIT_CYCLES) ? {4'h0, x[3:0]} : x);
    end
    for (int j = 0; j < 3; j++) begin
      t = (j == 0) ? OFS_WORK_REGISTER_A : (j == 1) ? OFS_AUX_OPERAND_REGISTER : OFS_STATUS_FLAGS_WORD;
      x = $random(seed);
      wr(t, ~x);
      op.bit_wr = 1'b1;
      for (int i = 0; i < 8; i++) begin
        op.bit_addr = t + 8'(i);
        op.bit_val = x[i];
        cyc(1);
      end
      op.bit_wr = 1'b0;
      rd(t, x);
    end
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      s = {1'b0, 7'($random(seed))};
      t = $random(seed);
      x = $random(seed);
      p2 = $random(seed);
      wr(OFS_ADDRESS_MODE_CONTROL, d);
      rd(OFS_ADDRESS_MODE_CONTROL, {4'h0, d[3], d[1], d[1:0]});
      chk(tbm, d[1]);
      wr(OFS_RI_PAGE_REGISTER, t);
      cyc(1);
      chk(rih, d[3] ? t : p2);
      wr(OFS_STACK_POINTER_LOW, s);
      wr(OFS_STACK_TOP_BYTE, t);
      op.push = 1'b1;
      op.push_data = x;
      cyc(1);
      op.push = 1'b0;
      waitsig(0, 1'b1);
      chk(saddr, {d[1] ? t : 8'h00, s + 8'h01});
      chk(swd, x);
      op.pop = 1'b1;
      cyc(1);
      op.pop = 1'b0;
      waitsig(1, 1'b1);
      chk(saddr, {d[1] ? t : 8'h00, s + 8'h01});
      rd(OFS_STACK_POINTER_LOW, s);
    end
    for (int n = 0; n < 16; n++) begin
      wr(OFS_FLASH_WAIT_CYCLES, 8'(n));
      freq = 1'b1;
      cyc(1);
      freq = 1'b0;
      waitsig(2, 1'b1);
      chk(k, n + 1);
      cyc(1);
    end
    wr(OFS_FLASH_WAIT_CYCLES, 8'h09);
    rd(OFS_FLASH_WAIT_CYCLES, 8'h09);
    stop = 1'b1;
    cyc(2);
    chk(oen, 1'b0);
    stop = 1'b0;
    cyc(2);
    chk(oen, 1'b1);
    fork pin.press(FC - 2); join_none
    quiet;
    chk(bad, 1'b0);
    below = 1'b1;
    quiet;
    below = 1'b0;
    chk(bad, 1'b0);
    wr(OFS_SUPPLY_DETECT_CTRL, 8'h85);
    cyc(1);
    chk(thr, 4'h5);
    for (int w = 0; w < 5; w++) src(w);
    end_of_test;
  end
endmodule : core_ctrl_tb
`default_nettype wire
